// ---- design/qa_watchdog_answer_status.sv ----
`timescale 1ns/1ps
// Contract
// - time-out flag judged each cycle end, resets zero, clears on status read.
// - time-out set if under four answers (four-answer mode) or none (single mode).
// - early flag set when the needed answers (four, or one in single mode) came in window one.
// - answer register reinitialised on power-on reset and reset state entry.
// - wrong-answer flag set at cycle end if any answer byte mismatched.
module qa_watchdog_answer_status
	import qa_wd_pkg::*;
#(
	parameter int TALLY_W = 3
) (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       clk_en,
	input  wire logic       reset_state,
	input  wire logic       watchdog_answer_mode,
	input  wire logic       answer_write_command,
	input  wire logic [7:0] answer_write_field,
	input  wire logic [7:0] answer_response_byte,
	input  wire logic       in_first_window,
	input  wire logic       cycle_end,
	input  wire logic       status_read,
	output logic      [7:0] watchdog_status_q,
	output logic      [7:0] watchdog_answer_q
);

	// ****************************************
	// parameter check
	// ****************************************
	// the tallies must count up to four answers before they saturate
	if (TALLY_W < 3) begin : g_tally_w_check
		$error("qa_watchdog_answer_status: TALLY_W too small");
	end

	// ****************************************
	// answer intake
	// ****************************************
	answer_write_t wr;
	logic          clr_cycle;
	logic          take;

	assign wr        = '{valid: answer_write_command, data: answer_write_field};
	// a write in the cycle-end clock counts toward the cycle that starts there
	assign clr_cycle = cycle_end | reset_state;
	assign take      = wr.valid & ~reset_state;

	// ****************************************
	// answer register
	// ****************************************
	logic [7:0] answer_d;

	always_comb begin
		answer_d = watchdog_answer_q;
		if (reset_state) begin
			answer_d = ANSWER_RST;
		end else if (wr.valid) begin
			answer_d = wr.data;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			watchdog_answer_q <= ANSWER_RST;
		end else if (clk_en) begin
			watchdog_answer_q <= answer_d;
		end
	end

	// ****************************************
	// answer countdown
	// ****************************************
	logic [1:0] cnt_field_d;
	logic [1:0] cnt_field_q;

	// wraps modulo four; power-on reset and the reset state reload it
	always_comb begin
		cnt_field_d = cnt_field_q;
		if (reset_state) begin
			cnt_field_d = watchdog_answer_mode ? CNT_RST_SINGLE : CNT_RST_QA;
		end else if (wr.valid) begin
			cnt_field_d = cnt_field_q - 2'h1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_field_q <= CNT_RST_QA;
		end else if (clk_en) begin
			cnt_field_q <= cnt_field_d;
		end
	end

	// ****************************************
	// mismatch memory
	// ****************************************
	logic mismatch_d;
	logic mismatch_q;

	always_comb begin
		mismatch_d = mismatch_q;
		if (clr_cycle) begin
			mismatch_d = 1'b0;
		end
		if (take && wr.data != answer_response_byte) begin
			mismatch_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mismatch_q <= 1'b0;
		end else if (clk_en) begin
			mismatch_q <= mismatch_d;
		end
	end

	// ****************************************
	// per-cycle tallies
	// ****************************************
	logic [TALLY_W-1:0] total_cnt;
	logic [TALLY_W-1:0] win1_cnt;
	logic               win1_take;

	assign win1_take = take & in_first_window;

	answer_tally #(.CNT_W(TALLY_W)) u_total (
		.clk     (clk),
		.nrst    (nrst),
		.en      (clk_en),
		.clr     (clr_cycle),
		.inc     (take),
		.count_q (total_cnt)
	);

	answer_tally #(.CNT_W(TALLY_W)) u_win1 (
		.clk     (clk),
		.nrst    (nrst),
		.en      (clk_en),
		.clr     (clr_cycle),
		.inc     (win1_take),
		.count_q (win1_cnt)
	);

	// ****************************************
	// answers needed in the current mode
	// ****************************************
	logic [TALLY_W-1:0] need_total;
	logic [TALLY_W-1:0] need_early;

	always_comb begin
		if (watchdog_answer_mode) begin
			need_total = TALLY_W'(ANSWERS_SINGLE);
			need_early = TALLY_W'(ANSWERS_SINGLE);
		end else begin
			need_total = TALLY_W'(ANSWERS_QA);
			need_early = TALLY_W'(ANSWERS_QA);
		end
	end

	// ****************************************
	// end-of-cycle judgement
	// ****************************************
	cycle_flags_t judged;

	always_comb begin
		judged.early   = win1_cnt >= need_early;
		judged.timeout = total_cnt < need_total;
		judged.wrong   = mismatch_q;
	end

	// ****************************************
	// flag register
	// ****************************************
	cycle_flags_t flags_d;
	cycle_flags_t flags_q;
	logic         flags_clear;
	logic         flags_judge;

	assign flags_clear = status_read | reset_state;
	assign flags_judge = cycle_end & ~reset_state;

	// a set at cycle end wins over a clear by read in the same cycle
	always_comb begin
		flags_d = flags_q;
		if (flags_clear) begin
			flags_d = '0;
		end
		if (flags_judge) begin
			flags_d = judged;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			flags_q <= '0;
		end else if (clk_en) begin
			flags_q <= flags_d;
		end
	end

	// ****************************************
	// status register image
	// ****************************************
	logic [7:0] status_d;

	// bits 7, 4 and 2 are not kept here and read as zero
	always_comb begin
		status_d                  = STATUS_RST;
		status_d[ST_EARLY_BIT]    = flags_d.early;
		status_d[ST_TIMEOUT_BIT]  = flags_d.timeout;
		status_d[ST_WRONG_BIT]    = flags_d.wrong;
		status_d[ST_CNT_LSB +: 2] = cnt_field_d;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			watchdog_status_q <= {1'b0, CNT_RST_QA, 5'h00};
		end else if (clk_en) begin
			watchdog_status_q <= status_d;
		end
	end
endmodule

// ---- pkg/qa_wd_pkg.sv ----
package qa_wd_pkg;
	// ****************************************
	// status register layout
	// ****************************************
	localparam int            ST_EARLY_BIT   = 0;
	localparam int            ST_TIMEOUT_BIT = 1;
	localparam int            ST_WRONG_BIT   = 3;
	localparam int            ST_CNT_LSB     = 5;
	localparam logic [7:0]    STATUS_RST     = 8'h00;
	localparam logic [1:0]    CNT_RST_QA     = 2'h3;
	localparam logic [1:0]    CNT_RST_SINGLE = 2'h1;
	localparam logic [2:0]    ANSWERS_QA     = 3'h4;
	localparam logic [2:0]    ANSWERS_SINGLE = 3'h1;
	localparam logic [7:0]    ANSWER_RST     = 8'h00;

	// ****************************************
	// carrier types
	// ****************************************
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} answer_write_t;

	typedef struct packed {
		logic early;
		logic timeout;
		logic wrong;
	} cycle_flags_t;
endpackage

// ---- design/answer_tally.sv ----
`timescale 1ns/1ps
module answer_tally
	import qa_wd_pkg::*;
#(
	parameter int CNT_W = 3
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             en,
	input  wire logic             clr,
	input  wire logic             inc,
	output logic      [CNT_W-1:0] count_q
);
	// the count must reach four answers before it saturates
	if (CNT_W < 3) begin : g_cnt_w_check
		$error("answer_tally: CNT_W too small");
	end

	logic [CNT_W-1:0] count_d;

	// saturating count, clear beats increment; an answer in the clear cycle starts the new count
	always_comb begin
		count_d = count_q;
		if (clr) begin
			count_d = inc ? CNT_W'(1) : '0;
		end else if (inc && count_q != {CNT_W{1'b1}}) begin
			count_d = count_q + CNT_W'(1);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count_q <= '0;
		end else if (en) begin
			count_q <= count_d;
		end
	end
endmodule

// ---- tb/qa_wd_checker.sv ----
`timescale 1ns/1ps
module qa_wd_checker
	import qa_wd_pkg::*;
(
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic       clk_en,
	input wire logic       reset_state,
	input wire logic       watchdog_answer_mode,
	input wire logic       answer_write_command,
	input wire logic [7:0] answer_write_field,
	input wire logic [7:0] answer_response_byte,
	input wire logic       in_first_window,
	input wire logic       cycle_end,
	input wire logic       status_read,
	input wire logic [7:0] watchdog_status_q,
	input wire logic [7:0] watchdog_answer_q
);
	// ****
	// status and answer register checks
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire logic       go = clk_en && !reset_state;
	wire logic [7:0] s  = watchdog_status_q;
	a_read_clears: assert property (go && status_read && !cycle_end |=> s[3:0] == 4'h0)
		else $error("flags kept after read");
	a_flags_hold: assert property (go && !cycle_end && !status_read |=> $stable(s[3:0]))
		else $error("flags moved mid cycle");
	a_timeout_at_end: assert property ($rose(s[1]) |-> $past(go) && $past(cycle_end))
		else $error("timeout rose off cycle end");
	a_early_at_end: assert property ($rose(s[0]) |-> $past(go) && $past(cycle_end))
		else $error("early rose off cycle end");
	a_wrong_at_end: assert property ($rose(s[3]) |-> $past(go) && $past(cycle_end))
		else $error("wrong rose off cycle end");
	a_reset_init: assert property (clk_en && reset_state |=> watchdog_answer_q == 8'h00)
		else $error("answer not cleared");
	a_answer_taken: assert property (go && answer_write_command
		|=> watchdog_answer_q == $past(answer_write_field)) else $error("answer not taken");
	a_count_step: assert property (go && answer_write_command
		|=> s[6:5] == $past(s[6:5]) - 2'h1) else $error("count not stepped");
	a_frozen_hold: assert property (!clk_en |=> $stable(s) && $stable(watchdog_answer_q))
		else $error("state moved while frozen");
	a_early_not_late: assert property (s[0] |-> !s[1])
		else $error("early and timeout together");
	c_end_read: cover property (go && cycle_end && status_read);
	c_mode0: cover property (go && cycle_end && !watchdog_answer_mode);
	c_mode1: cover property (go && cycle_end && watchdog_answer_mode);
	c_read: cover property (go && status_read);
endmodule
bind qa_watchdog_answer_status qa_wd_checker chk (.*);

// ---- tb/mcu_model.sv ----
`timescale 1ns/1ps
module mcu_model (
	input  wire logic       clk,
	output logic            cmd,
	output logic      [7:0] field,
	output logic      [7:0] resp
);
	// ****
	// answer writer
	// ****
	initial begin
		cmd = 1'b0;
		field = 8'h00;
		resp = 8'h00;
	end
	task automatic answer(input logic [7:0] f, input logic [7:0] r);
		@(negedge clk);
		cmd <= 1'b1;
		field <= f;
		resp <= r;
		@(negedge clk);
		cmd <= 1'b0;
		field <= ~f;
	endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	import qa_wd_pkg::*;
	// ****
	// bench
	// ****
	logic       clk, nrst, en, rst_st, mode, win, ce, rd, cmd;
	logic [7:0] fld, rsp, st, ans;
	int         bad_count, samples_checked;
	qa_watchdog_answer_status dut (.clk(clk), .nrst(nrst), .clk_en(en), .reset_state(rst_st),
		.watchdog_answer_mode(mode), .answer_write_command(cmd), .answer_write_field(fld),
		.answer_response_byte(rsp), .in_first_window(win), .cycle_end(ce), .status_read(rd),
		.watchdog_status_q(st), .watchdog_answer_q(ans));
	mcu_model mcu (.clk(clk), .cmd(cmd), .field(fld), .resp(rsp));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task chk(input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task results;
		$display("checked %0d bad %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	function logic [7:0] sv(logic [1:0] c, logic w, logic t, logic e);
		return {1'b0, c, 1'b0, w, 1'b0, t, e};
	endfunction
	task end_cycle;
		@(negedge clk) ce = 1'b1;
		@(negedge clk) ce = 1'b0;
	endtask
	task four_early;
		win = 1'b1;
		repeat (4) mcu.answer(8'h5A, 8'h5A);
		chk(ans, 8'h5A);
		end_cycle();
		chk(st, sv(2'h3, 1'b0, 1'b0, 1'b1));
		@(negedge clk) rd = 1'b1;
		@(negedge clk) rd = 1'b0;
		chk(st, sv(2'h3, 1'b0, 1'b0, 1'b0));
	endtask
	task three_late_wrong;
		win = 1'b0;
		mcu.answer(8'h11, 8'h11);
		mcu.answer(8'h22, 8'h99);
		mcu.answer(8'h33, 8'h33);
		end_cycle();
		chk(st, sv(2'h0, 1'b1, 1'b1, 1'b0));
	endtask
	task single_mode;
		mode = 1'b1;
		@(negedge clk) rst_st = 1'b1;
		@(negedge clk) rst_st = 1'b0;
		chk(ans, 8'h00);
		chk(st, sv(2'h1, 1'b0, 1'b0, 1'b0));
		end_cycle();
		chk(st, sv(2'h1, 1'b0, 1'b1, 1'b0));
		win = 1'b1;
		mcu.answer(8'hC3, 8'hC3);
		end_cycle();
		chk(st, sv(2'h0, 1'b0, 1'b0, 1'b1));
	endtask
	task frozen;
		@(negedge clk) en = 1'b0;
		mcu.answer(8'h3C, 8'h00);
		end_cycle();
		chk(ans, 8'hC3);
		chk(st, sv(2'h0, 1'b0, 1'b0, 1'b1));
		en = 1'b1;
	endtask
	task single_late;
		win = 1'b0;
		mcu.answer(8'h96, 8'h96);
		end_cycle();
		chk(st, sv(2'h3, 1'b0, 1'b0, 1'b0));
		fork
			mcu.answer(8'h69, 8'h00);
			begin
				@(negedge clk) {ce, rd} = 2'h3;
				@(negedge clk) {ce, rd} = 2'h0;
			end
		join
		chk(st, sv(2'h2, 1'b0, 1'b1, 1'b0));
		end_cycle();
		chk(st, sv(2'h2, 1'b1, 1'b0, 1'b0));
	endtask
	initial begin
		{nrst, rst_st, mode, win, ce, rd} = 6'h00;
		en = 1'b1;
		bad_count = 0;
		samples_checked = 0;
		repeat (6) @(negedge clk);
		nrst = 1'b1;
		chk(st, 8'h60);
		fork
			begin
				four_early();
				three_late_wrong();
				single_mode();
				frozen();
				single_late();
			end
			begin
				repeat (2000) @(negedge clk);
				bad_count++; // run limit used up
			end
		join_any
		results();
	end
endmodule
